// *** logic/lfp_regs.vh ***
// Constants for the lock and fuse protection logic
`ifndef LFP_REGS_VH
`define LFP_REGS_VH
`define LFP_LOCK_W 6
`define LFP_FUSE_W 13
// Lock bit positions
`define LFP_LK_MAIN_A 0
`define LFP_LK_MAIN_B 1
`define LFP_LK_APP_A 2
`define LFP_LK_APP_B 3
`define LFP_LK_BOOT_A 4
`define LFP_LK_BOOT_B 5
`define LFP_LOCK_RST 6'h3f
// Fuse positions: low group 5..0, high group 12..6 order below
`define LFP_FU_CKSEL_LO 0
`define LFP_FU_BOD_EN 4
`define LFP_FU_BOD_LVL 5
`define LFP_FU_BOOT_RST 6
`define LFP_FU_BOOTSZ_LO 7
`define LFP_FU_EEPROM_PRESERVE_FUSE 9
`define LFP_FU_SERIAL_EN 10
`define LFP_FU_TEST_EN 11
`define LFP_FU_DEBUG_EN 12
// Defaults: debug 1, test 0, serial 0, eeprom_preserve_fuse 1, bootsz 11, boot_reset_fuse 1, bodlvl 1, brownout_enable_fuse 1, 0010
`define LFP_FUSE_RST 13'h13f2
// Programmer commands
`define LFP_CMD_ERASE 8'h80
`define LFP_CMD_WR_FUSE 8'h40
`define LFP_CMD_WR_LOCK 8'h20
`define LFP_CMD_RD_SIG 8'h08
`define LFP_CMD_RD_FL 8'h04
// Ports
`define LFP_PORT_PAR 2'h0
`define LFP_PORT_SER 2'h1
`define LFP_PORT_TEST 2'h2
// Minimum erase hold in clocks before done is accepted
`define LFP_ERASE_CYC 16'h0010
`endif

// *** logic/lfp_nv_cell.v ***
// One non-volatile field: reset-latched copy with guarded write and erase
`timescale 1ns/1ps
module lfp_nv_cell #(
  parameter W = 6,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire mclk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [W-1:0] wr_data_i,
  input wire clr_i,
  output wire [W-1:0] val_o
);
  reg [W-1:0] cell_q;
  // Array value survives reset; only writes and erase alter it
  always @(posedge mclk_i) begin
    if (clr_i) begin
      cell_q <= {W{1'b1}};
    end else if (wr_i) begin
      cell_q <= wr_data_i;
    end
  end
  // Copy used by decoding; reloaded whenever the array changes
  reg [W-1:0] copy_q;
  reg init_q;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      copy_q <= INIT;
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      copy_q <= init_q ? cell_q : INIT;
    end
  end
  // First cycle after reset before array is written still reads INIT
  initial cell_q = INIT;
  assign val_o = copy_q;
endmodule

// *** logic/lfp_sig_rom.v ***
// Signature and calibration byte store with registered read data
`timescale 1ns/1ps
module lfp_sig_rom #(
  parameter [7:0] SIG0 = 8'h5a, // Arbitrary identity value
  parameter [7:0] SIG1 = 8'h3c, // Arbitrary identity value
  parameter [7:0] SIG2 = 8'ha5, // Arbitrary identity value
  parameter [7:0] CAL = 8'h80
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [1:0] addr_i,
  input wire hi_i,
  output reg [7:0] data_o
);
  // Registered lookup; unused addresses read as ff
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
    end else if (hi_i) begin
      data_o <= (addr_i == 2'h0) ? CAL : 8'hff;
    end else begin
      case (addr_i)
        2'h0: data_o <= SIG0;
        2'h1: data_o <= SIG1;
        2'h2: data_o <= SIG2;
        default: data_o <= 8'hff;
      endcase
    end
  end
endmodule

// *** logic/lfp_top.v ***
// Lock and fuse protection logic: storage, programmer gating, self-write gating
// Function
// - six lock bits, only erase restores
// - lock 10 stops writes, locks fuses except on test port
// - lock 00 stops writes and verify
// - app lock 10/00 blocks app stores
// - app lock 00/01 blocks boot reads
// - boot lock 10/00 blocks boot stores
// - boot lock 00/01 blocks app reads
// - thirteen fuses, serial enable not serial
// - debug needs debug and test fuses
// - test fuse routes test port pins
// - serial fuse enables serial download
// - eeprom preserve refused when locked
// - boot size fuses pick boot section
// - boot reset fuse picks reset vector
// - brownout level fuse picks threshold
// - brownout enable fuse starts detector
// - clock select fuses, default 0010
// - erase keeps fuses; lock a blocks fuses except on test port
// - three signature bytes, serial or parallel
// - calibration byte at high address zero
// - erase clears flash, eeprom unless preserved, locks last
`timescale 1ns/1ps
`include "lfp_regs.vh"
module lfp_top #(
  parameter [7:0] SIG0 = 8'h5a, // Arbitrary identity value
  parameter [7:0] SIG1 = 8'h3c, // Arbitrary identity value
  parameter [7:0] SIG2 = 8'ha5, // Arbitrary identity value
  parameter [7:0] CAL = 8'h80,
  parameter [15:0] ERASE_CYC = `LFP_ERASE_CYC
) (
  input wire mclk_i,
  input wire rst_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_i,
  input wire [1:0] cmd_port_i,
  input wire [12:0] cmd_data_i,
  input wire [1:0] cmd_addr_i,
  input wire cmd_hi_i,
  output wire cmd_ready_o,
  output reg cmd_refused_o,
  output reg [12:0] rd_data_o,
  output reg rd_valid_o,
  input wire mem_wr_req_i,
  input wire mem_rd_req_i,
  output wire mem_wr_allow_o,
  output wire mem_rd_allow_o,
  output reg flash_erase_o,
  output reg eeprom_erase_o,
  input wire flash_erase_done_i,
  input wire spm_store_i,
  input wire lpm_load_i,
  input wire tgt_boot_i,
  input wire exec_boot_i,
  input wire vect_in_boot_i,
  output wire spm_allow_o,
  output wire lpm_allow_o,
  output wire irq_mask_o,
  output wire [5:0] lock_bits_o,
  output wire [12:0] fuse_bits_o,
  output wire debug_en_o,
  output wire clk_keep_o,
  output wire test_port_en_o,
  output wire serial_dl_en_o,
  output wire [1:0] boot_size_o,
  output wire [15:0] reset_vector_o,
  output wire bod_level_o,
  output wire bod_en_o,
  output wire [3:0] clock_select_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_LOCKS = 2'h2;
  wire [5:0] lock;
  wire [12:0] fuse;
  reg [1:0] st_q;
  reg [15:0] cnt_q;
  reg lk_wr, fu_wr, lk_clr;
  // Declared ahead of the fuse store that consumes it
  reg [12:0] fuse_wdata;
  wire [7:0] sig_byte;
  reg sig_pend_q;
  // Decoded lock modes
  wire main_a = lock[`LFP_LK_MAIN_A];
  wire main_b = lock[`LFP_LK_MAIN_B];
  wire app_a = lock[`LFP_LK_APP_A];
  wire app_b = lock[`LFP_LK_APP_B];
  wire boot_a = lock[`LFP_LK_BOOT_A];
  wire boot_b = lock[`LFP_LK_BOOT_B];
  wire no_write = ~main_a;
  wire no_verify = ~main_a & ~main_b;
  wire fuse_locked = ~main_a;
  wire idle = (st_q == ST_IDLE);
  // Lock store; programming clears bits only, erase sets all
  lfp_nv_cell #(.W(6), .INIT(`LFP_LOCK_RST)) u_lock (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(lk_wr),
    .wr_data_i(lock & cmd_data_i[5:0]),
    .clr_i(lk_clr),
    .val_o(lock)
  );
  // Fuse store; untouched by erase
  lfp_nv_cell #(.W(13), .INIT(`LFP_FUSE_RST)) u_fuse (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_i(fu_wr),
    .wr_data_i(fuse_wdata),
    .clr_i(1'b0),
    .val_o(fuse)
  );
  // Fuse write data: serial cannot touch serial enable, preserve cannot be programmed to 0 when locked
  always @* begin
    fuse_wdata = cmd_data_i;
    if (cmd_port_i == `LFP_PORT_SER) begin
      fuse_wdata[`LFP_FU_SERIAL_EN] = fuse[`LFP_FU_SERIAL_EN];
    end
    if (lock != 6'h3f && !cmd_data_i[`LFP_FU_EEPROM_PRESERVE_FUSE]) begin
      fuse_wdata[`LFP_FU_EEPROM_PRESERVE_FUSE] = fuse[`LFP_FU_EEPROM_PRESERVE_FUSE];
    end
  end
  // Command acceptance; fuse lock applies to every port except the test port
  always @* begin
    lk_wr = 1'b0;
    fu_wr = 1'b0;
    if (cmd_valid_i && idle) begin
      if (cmd_i == `LFP_CMD_WR_LOCK) begin
        lk_wr = 1'b1;
      end
      if (cmd_i == `LFP_CMD_WR_FUSE) begin
        fu_wr = !(fuse_locked && cmd_port_i != `LFP_PORT_TEST);
      end
    end
  end
  assign cmd_ready_o = idle;
  // Erase sequence: memories first, lock bits restored after flash is done
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      flash_erase_o <= 1'b0;
      eeprom_erase_o <= 1'b0;
      lk_clr <= 1'b0;
    end else begin
      lk_clr <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cmd_valid_i && cmd_i == `LFP_CMD_ERASE) begin
            st_q <= ST_ERASE;
            cnt_q <= ERASE_CYC;
            flash_erase_o <= 1'b1;
            eeprom_erase_o <= ~fuse[`LFP_FU_EEPROM_PRESERVE_FUSE] ? 1'b0 : 1'b1;
          end
        end
        ST_ERASE: begin
          // Minimum hold guards a done pulse that arrives too early
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (flash_erase_done_i) begin
            flash_erase_o <= 1'b0;
            eeprom_erase_o <= 1'b0;
            st_q <= ST_LOCKS;
          end
        end
        ST_LOCKS: begin
          lk_clr <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // Signature and calibration store
  lfp_sig_rom #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CAL(CAL)) u_sig (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(cmd_addr_i),
    .hi_i(cmd_hi_i),
    .data_o(sig_byte)
  );
  // Read answers; signature from serial or parallel, one cycle late
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sig_pend_q <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 13'h0000;
      cmd_refused_o <= 1'b0;
    end else begin
      sig_pend_q <= cmd_valid_i && idle && cmd_i == `LFP_CMD_RD_SIG &&
        cmd_port_i != `LFP_PORT_TEST;
      rd_valid_o <= 1'b0;
      cmd_refused_o <= cmd_valid_i && idle && cmd_i == `LFP_CMD_WR_FUSE && !fu_wr;
      if (sig_pend_q) begin
        rd_valid_o <= 1'b1;
        rd_data_o <= {5'h00, sig_byte};
      end else if (cmd_valid_i && idle && cmd_i == `LFP_CMD_RD_FL) begin
        rd_valid_o <= 1'b1;
        rd_data_o <= cmd_hi_i ? {7'h00, lock} : fuse;
      end
    end
  end
  // Programmer access to flash and eeprom
  assign mem_wr_allow_o = mem_wr_req_i & ~no_write;
  assign mem_rd_allow_o = mem_rd_req_i & ~no_verify;
  // Self-programming gating per section
  wire app_no_store = ~app_a;
  wire app_no_load = ~app_b;
  wire boot_no_store = ~boot_a;
  wire boot_no_load = ~boot_b;
  assign spm_allow_o = spm_store_i &
    (tgt_boot_i ? ~boot_no_store : ~app_no_store);
  assign lpm_allow_o = lpm_load_i & ~((exec_boot_i && !tgt_boot_i && app_no_load) ||
    (!exec_boot_i && tgt_boot_i && boot_no_load));
  assign irq_mask_o = (vect_in_boot_i && !exec_boot_i && app_no_load) ||
    (!vect_in_boot_i && exec_boot_i && boot_no_load);
  // Fuse decodes
  assign lock_bits_o = lock;
  assign fuse_bits_o = fuse;
  assign test_port_en_o = ~fuse[`LFP_FU_TEST_EN];
  assign debug_en_o = ~fuse[`LFP_FU_DEBUG_EN] & ~fuse[`LFP_FU_TEST_EN];
  assign clk_keep_o = ~fuse[`LFP_FU_DEBUG_EN];
  assign serial_dl_en_o = ~fuse[`LFP_FU_SERIAL_EN];
  assign boot_size_o = fuse[`LFP_FU_BOOTSZ_LO+1:`LFP_FU_BOOTSZ_LO];
  // Boot start in words: 11->256 words from top, each step down doubles
  reg [15:0] boot_start;
  always @* begin
    case (boot_size_o)
      2'h3: boot_start = 16'h3f00;
      2'h2: boot_start = 16'h3e00;
      2'h1: boot_start = 16'h3c00;
      default: boot_start = 16'h3800;
    endcase
  end
  assign reset_vector_o = fuse[`LFP_FU_BOOT_RST] ? 16'h0000 : boot_start;
  assign bod_level_o = fuse[`LFP_FU_BOD_LVL];
  assign bod_en_o = ~fuse[`LFP_FU_BOD_EN];
  assign clock_select_o = fuse[`LFP_FU_CKSEL_LO+3:`LFP_FU_CKSEL_LO];
endmodule

// *** dv/lfp_top_assertions.sv ***
// Port checker for the lock and fuse protection logic
`timescale 1ns/1ps
`include "lfp_regs.vh"
module lfp_top_assertions (
  input wire mclk_i,
  input wire rst_i,
  input wire cmd_valid_i,
  input wire [7:0] cmd_i,
  input wire [1:0] cmd_port_i,
  input wire cmd_ready_o,
  input wire cmd_refused_o,
  input wire mem_wr_req_i,
  input wire mem_rd_req_i,
  input wire mem_wr_allow_o,
  input wire mem_rd_allow_o,
  input wire flash_erase_o,
  input wire spm_store_i,
  input wire lpm_load_i,
  input wire tgt_boot_i,
  input wire exec_boot_i,
  input wire spm_allow_o,
  input wire lpm_allow_o,
  input wire [5:0] lock_bits_o,
  input wire [12:0] fuse_bits_o,
  input wire debug_en_o,
  input wire serial_dl_en_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire tk = cmd_valid_i && cmd_ready_o;
  reg [3:0] er_q;
  // Recent-erase window, so a lock bit may only return to one shortly after an erase
  always @(posedge mclk_i or posedge rst_i)
    if (rst_i) er_q <= 4'h0;
    else if (flash_erase_o) er_q <= 4'h8;
    else if (er_q != 4'h0) er_q <= er_q - 4'h1;
  sequence fuse_wr_locked;
    tk && cmd_i == `LFP_CMD_WR_FUSE && !lock_bits_o[0] && cmd_port_i != `LFP_PORT_TEST;
  endsequence
  sequence fuse_kept;
    $stable(fuse_bits_o) [*3];
  endsequence
  fuse_refuse_a: assert property (fuse_wr_locked |-> ##[1:2] cmd_refused_o)
    else $error("locked fuse write not refused");
  fuse_hold_a: assert property (fuse_wr_locked |=> fuse_kept)
    else $error("locked fuse write changed fuses");
  prog_write_a: assert property (mem_wr_req_i && !lock_bits_o[0] |-> !mem_wr_allow_o)
    else $error("programming write granted while locked");
  prog_verify_a: assert property (mem_rd_req_i && lock_bits_o[1:0] == 2'b00 |-> !mem_rd_allow_o)
    else $error("verify read granted in full lock");
  app_store_a: assert property (spm_store_i && !tgt_boot_i && !lock_bits_o[2] |-> !spm_allow_o)
    else $error("application store not suppressed");
  boot_store_a: assert property (spm_store_i && tgt_boot_i && !lock_bits_o[4] |-> !spm_allow_o)
    else $error("boot store not suppressed");
  app_load_a: assert property (lpm_load_i && exec_boot_i && !tgt_boot_i && !lock_bits_o[3]
    |-> !lpm_allow_o)
    else $error("application load from boot code granted");
  boot_load_a: assert property (lpm_load_i && !exec_boot_i && tgt_boot_i && !lock_bits_o[5]
    |-> !lpm_allow_o)
    else $error("boot load from application code granted");
  debug_gate_a: assert property (debug_en_o == (!fuse_bits_o[12] && !fuse_bits_o[11]))
    else $error("debug enable decode wrong");
  serial_gate_a: assert property (serial_dl_en_o == !fuse_bits_o[10])
    else $error("serial download decode wrong");
  lock_rise_a: assert property (|(lock_bits_o & ~$past(lock_bits_o)) |-> er_q != 4'h0)
    else $error("lock bit returned to one without erase");
  erase_fuse_a: assert property (flash_erase_o |=> $stable(fuse_bits_o))
    else $error("fuses changed during erase");
  erase_start_a: assert property (tk && cmd_i == `LFP_CMD_ERASE |=> flash_erase_o && !cmd_ready_o)
    else $error("erase did not start");
endmodule

// *** dv/lfp_array_model.sv ***
// Flash array stand-in that reports erase completion
`timescale 1ns/1ps
module lfp_array_model #(
  parameter DLY = 10
) (
  input wire mclk_i,
  input wire erase_i,
  output reg done_o
);
  integer n;
  initial begin
    done_o = 1'b0;
    n = 0;
  end
  // Slow array: done only after DLY cycles, and dropped once erase ends
  always @(posedge mclk_i) begin
    n <= erase_i ? n + 1 : 0;
    done_o <= erase_i && n >= DLY;
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the lock and fuse protection logic
`timescale 1ns/1ps
`include "lfp_regs.vh"
module tb;
  localparam [7:0] S0 = 8'h21, S1 = 8'h43, S2 = 8'h65, CL = 8'h87; // Arbitrary identity values
  reg mclk_i, rst_i, cv, hi, mwr, mrd, spm, lpm, tgtb, exb, vib;
  reg [7:0] cmd;
  reg [1:0] port, addr;
  reg [12:0] data, d, fx;
  reg [31:0] rs;
  integer n_mismatch, total_checks, i, k, j;
  wire rdy, rfs, rdv, mwa, mra, fe, done, spa, lpa;
  wire [12:0] rdd, fuse;
  wire [5:0] lock;
  wire [15:0] rv;
  wire [3:0] cs;
  wire tpe, boe, ee;
  lfp_top #(.SIG0(S0), .SIG1(S1), .SIG2(S2), .CAL(CL), .ERASE_CYC(16'h0004)) lfp_top_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cv), .cmd_i(cmd), .cmd_port_i(port),
    .cmd_data_i(data), .cmd_addr_i(addr), .cmd_hi_i(hi), .cmd_ready_o(rdy),
    .cmd_refused_o(rfs), .rd_data_o(rdd), .rd_valid_o(rdv), .mem_wr_req_i(mwr),
    .mem_rd_req_i(mrd), .mem_wr_allow_o(mwa), .mem_rd_allow_o(mra), .flash_erase_o(fe),
    .eeprom_erase_o(ee), .flash_erase_done_i(done), .spm_store_i(spm), .lpm_load_i(lpm),
    .tgt_boot_i(tgtb), .exec_boot_i(exb), .vect_in_boot_i(vib), .spm_allow_o(spa),
    .lpm_allow_o(lpa), .irq_mask_o(), .lock_bits_o(lock), .fuse_bits_o(fuse), .debug_en_o(),
    .clk_keep_o(), .test_port_en_o(tpe), .serial_dl_en_o(), .boot_size_o(),
    .reset_vector_o(rv), .bod_level_o(), .bod_en_o(boe), .clock_select_o(cs));
  lfp_array_model #(.DLY(10)) lfp_array_model_inst (.mclk_i(mclk_i), .erase_i(fe), .done_o(done));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task idle;
    for (i = 0; i < 200 && rdy !== 1'b1; i = i + 1) begin
      @(posedge mclk_i);
      #1;
    end
  endtask
  // One-cycle command strobe, launched only while the block is idle
  task run(input [7:0] c, input [1:0] p, input [12:0] v, input [1:0] a, input h);
    begin
      idle;
      {cmd, port, data, addr, hi, cv} = {c, p, v, a, h, 1'b1};
      @(posedge mclk_i);
      #1 cv = 1'b0;
    end
  endtask
  task wr(input [7:0] c, input [1:0] p, input [12:0] v);
    begin
      run(c, p, v, 2'h0, 1'b0);
      repeat (3) @(posedge mclk_i);
      #1;
    end
  endtask
  task rd(input [7:0] c, input [1:0] a, input h, input [12:0] e);
    begin
      run(c, `LFP_PORT_PAR, 13'h0, a, h);
      for (i = 0; i < 8 && rdv !== 1'b1; i = i + 1) begin
        @(posedge mclk_i);
        #1;
      end
      chk(rdd, e);
    end
  endtask
  // Random core and programmer traffic; the checker judges each grant
  task sweep;
    for (j = 0; j < 40; j = j + 1) begin
      rs = xs(rs);
      {mwr, mrd, spm, lpm, tgtb, exb, vib} = rs[6:0];
      @(posedge mclk_i);
      #1;
    end
  endtask
  task report_and_stop;
    begin
      if (n_mismatch == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial begin
    {cv, cmd, port, data, addr, hi, mwr, mrd, spm, lpm, tgtb, exb, vib} = '0;
    rst_i = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    rs = 32'd36;
    repeat (8) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 chk(fuse, `LFP_FUSE_RST);
    chk(lock, `LFP_LOCK_RST);
    chk(rv, 16'h0000);
    chk(cs, 4'h2);
    chk(tpe, 1'b1);
    chk(boe, 1'b0);
    sweep;
    // Random fuse images: parallel takes all bits, serial never moves the download enable
    for (k = 0; k < 6; k = k + 1) begin
      rs = xs(rs);
      d = rs[12:0];
      wr(`LFP_CMD_WR_FUSE, `LFP_PORT_PAR, d);
      chk(fuse, d);
      rd(`LFP_CMD_RD_FL, 2'h0, 1'b0, d);
      rs = xs(rs);
      fx = {rs[12:11], ~d[10], rs[9:0]};
      wr(`LFP_CMD_WR_FUSE, `LFP_PORT_SER, fx);
      chk(fuse, {fx[12:11], d[10], fx[9:0]});
    end
    wr(`LFP_CMD_WR_FUSE, `LFP_PORT_PAR, `LFP_FUSE_RST);
    rd(`LFP_CMD_RD_SIG, 2'h0, 1'b0, {5'h0, S0});
    rd(`LFP_CMD_RD_SIG, 2'h1, 1'b0, {5'h0, S1});
    rd(`LFP_CMD_RD_SIG, 2'h2, 1'b0, {5'h0, S2});
    rd(`LFP_CMD_RD_SIG, 2'h0, 1'b1, {5'h0, CL});
    // Step the locks down; fuses freeze and a lock never climbs back by writing
    wr(`LFP_CMD_WR_LOCK, `LFP_PORT_PAR, 13'h003e);
    chk(lock, 6'h3e);
    wr(`LFP_CMD_WR_FUSE, `LFP_PORT_PAR, 13'h0000);
    wr(`LFP_CMD_WR_FUSE, `LFP_PORT_SER, 13'h0000);
    chk(fuse, `LFP_FUSE_RST);
    sweep;
    wr(`LFP_CMD_WR_LOCK, `LFP_PORT_PAR, 13'h002a);
    wr(`LFP_CMD_WR_LOCK, `LFP_PORT_PAR, 13'h003f);
    chk(lock, 6'h2a);
    sweep;
    wr(`LFP_CMD_WR_LOCK, `LFP_PORT_PAR, 13'h0015);
    chk(lock, 6'h00);
    sweep;
    // Erase with a slow array: locks return, fuses stay, fuse writes open again
    run(`LFP_CMD_ERASE, `LFP_PORT_PAR, 13'h0000, 2'h0, 1'b0);
    chk(ee, 1'b1);
    idle;
    // Array cell clears one edge after ready returns, the copy one edge later
    repeat (2) @(posedge mclk_i);
    #1 chk(lock, `LFP_LOCK_RST);
    chk(fuse, `LFP_FUSE_RST);
    wr(`LFP_CMD_WR_FUSE, `LFP_PORT_PAR, 13'h1bf2);
    chk(fuse, 13'h1bf2);
    report_and_stop;
  end
endmodule
bind lfp_top lfp_top_assertions lfp_top_assertions_inst (.*);
